// *** verilog/fan_port_consts.svh ***
`ifndef FAN_PORT_CONSTS_SVH
`define FAN_PORT_CONSTS_SVH
`define FSP_TARGET_ADDR    7'h55
`define FSP_REG_APPLIED    8'h80
`define FSP_REG_TEMP       8'h8a
`define FSP_REG_FAILS      8'h90
`define FSP_REG_TRIES      8'h91
`define FSP_REG_FAULT      8'h93
`define FSP_REG_LOCK       8'h94
`define FSP_REG_DEMAND     8'ha5
`define FSP_PARAM_BASE     3'h2
`define FSP_PARAM_FIRST    8'h48
`define FSP_PARAM_LAST     8'h5e
`define FSP_LOCK_CLEAR_BIT 15
`define FSP_DUTY_FULL      9'h1ff
`define FSP_DUTY_OFF       9'h000
`define FSP_H_CTRL         2'h0
`define FSP_H_WDATA        2'h1
`define FSP_H_STATUS       2'h2
`define FSP_H_RDATA        2'h3
`define FSP_H_CTRL_READ    8
`define FSP_H_LAST_WRITE   4'h5
`define FSP_H_LAST_READ    4'h8
`define FSP_CLK_NS         100
`define FSP_QUARTER_NS     700
`define FSP_QUARTER_CYC    ((`FSP_QUARTER_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`endif

// *** verilog/fan_port_pkg.sv ***
package fan_port_pkg;
    typedef logic [8:0]  duty_t;
    typedef logic [15:0] word_t;
    typedef logic [7:0]  index_t;
    typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_RACK} dev_state_t;
    typedef enum logic [0:0] {H_IDLE, H_RUN} host_state_t;
    typedef enum logic [1:0] {OP_START, OP_TX, OP_RX, OP_STOP} host_op_t;
endpackage

// *** verilog/fan_link_if.sv ***
interface fan_link_if;
    logic host_scl_out;
    logic host_scl_oe;
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic scl;
    logic sda;
    // open-drain wired-and with pull-up
    assign scl = !(host_scl_oe && !host_scl_out);
    assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));
    modport host (output host_scl_out, output host_scl_oe, output host_sda_out, output host_sda_oe,
                  input scl, input sda);
    modport device (output dev_sda_out, output dev_sda_oe, input scl, input sda);
endinterface

// *** verilog/line_sync.sv ***
module line_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // line
    input  wire logic d,
    output logic      q
);
    logic meta;
    // lines idle high, so reset to high to avoid a false start
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= 1'b1;
            q    <= 1'b1;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// *** verilog/fan_port_device.sv ***
// The implementer's own choice: strobed register access.
`include "fan_port_consts.svh"
module fan_port_device (
    // clock and reset
    input  wire logic                 REF_CLK,
    input  wire logic                 RST_N,
    // serial link
    fan_link_if.device                LINK,
    // measured pwm duty
    input  wire fan_port_pkg::duty_t  PWM_DUTY,
    // motor status
    input  wire fan_port_pkg::duty_t  DUTY_APPLIED,
    input  wire logic [7:0]           DIE_TEMP,
    input  wire logic [9:0]           FAULT,
    input  wire logic [6:0]           LOCK_EVENT,
    input  wire logic                 STARTUP_TRY,
    input  wire logic                 STARTUP_FAIL,
    // motor command
    output fan_port_pkg::duty_t       DUTY_CMD,
    output logic                      MOTOR_RUN,
    output logic                      SERIAL_MODE,
    output logic                      PARAMS_LOADED
);
    import fan_port_pkg::*;

    dev_state_t  state;
    logic        scl_s;
    logic        sda_s;
    logic        scl_d;
    logic        sda_d;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic [3:0]  bit_cnt;
    logic [2:0]  byte_no;
    logic [7:0]  shift;
    logic        rw;
    logic        second;
    logic        rack_ok;
    word_t       tx;
    index_t      reg_index;
    logic [7:0]  wr_hi;
    logic        wr_stb;
    word_t       wr_data;
    logic        hit;
    logic        sda_low;
    word_t       rd_word;
    duty_t       speed_demand;
    logic        run;
    logic        low_seen;
    logic [22:0] loaded_mask;
    word_t       param_mem [0:31];
    word_t       count [0:1];
    logic [6:0]  lock_flags;
    duty_t       next_duty;

    function automatic word_t reg_read(input index_t idx);
        word_t r;
        r = 16'h0000;
        if (idx[7:5] == `FSP_PARAM_BASE) begin
            r = param_mem[idx[4:0]];
        end else begin
            case (idx)
                `FSP_REG_APPLIED: r = {7'h00, DUTY_APPLIED};
                `FSP_REG_TEMP:    r = {8'h00, DIE_TEMP};
                `FSP_REG_FAILS:   r = count[0];
                `FSP_REG_TRIES:   r = count[1];
                `FSP_REG_FAULT:   r = {6'h00, FAULT};
                `FSP_REG_LOCK:    r = {9'h000, lock_flags};
                `FSP_REG_DEMAND:  r = {7'h00, speed_demand};
                default:          r = 16'h0000;
            endcase
        end
        return r;
    endfunction

    function automatic logic wr_to(input index_t idx);
        return wr_stb && (reg_index == idx);
    endfunction

    // speed pin is the clock, tach pin the data
    line_sync u_scl_sync (.clk(REF_CLK), .rst_n(RST_N), .d(LINK.scl), .q(scl_s));
    line_sync u_sda_sync (.clk(REF_CLK), .rst_n(RST_N), .d(LINK.sda), .q(sda_s));

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // both lines pass equal delays, so start and stop keep their order
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_c  = scl_s && scl_d && sda_d && !sda_s;
    assign stop_c   = scl_s && scl_d && !sda_d && sda_s;

    always_comb begin
        rd_word = reg_read(reg_index);
    end

    // target state machine; any start is taken with no unlock
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state     <= ST_IDLE;
            bit_cnt   <= 4'h0;
            byte_no   <= 3'h0;
            shift     <= 8'h00;
            rw        <= 1'b0;
            second    <= 1'b0;
            rack_ok   <= 1'b0;
            tx        <= 16'h0000;
            reg_index <= 8'h00;
            wr_hi     <= 8'h00;
            wr_stb    <= 1'b0;
            wr_data   <= 16'h0000;
            hit       <= 1'b0;
            sda_low   <= 1'b0;
        end else begin
            wr_stb <= 1'b0;
            hit    <= 1'b0;
            if (start_c) begin
                state   <= ST_RECV;
                bit_cnt <= 4'h0;
                byte_no <= 3'h0;
                sda_low <= 1'b0;
            end else if (stop_c) begin
                state   <= ST_IDLE;
                sda_low <= 1'b0;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        sda_low <= 1'b0;
                    end
                    ST_RECV: begin
                        if (scl_rise) begin
                            shift   <= {shift[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            byte_no <= byte_no + 3'h1;
                            state   <= ST_ACK;
                            sda_low <= 1'b1;
                            case (byte_no)
                                3'h0: begin
                                    if (shift[7:1] != `FSP_TARGET_ADDR) begin
                                        state   <= ST_IDLE;
                                        sda_low <= 1'b0;
                                    end else begin
                                        rw     <= shift[0];
                                        second <= 1'b0;
                                        hit    <= 1'b1;
                                    end
                                end
                                3'h1: reg_index <= shift;
                                3'h2: wr_hi <= shift;
                                3'h3: begin
                                    wr_stb  <= 1'b1;
                                    wr_data <= {wr_hi, shift};
                                end
                                default: begin
                                    state   <= ST_IDLE;
                                    sda_low <= 1'b0;
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (rw) begin
                                state   <= ST_SEND;
                                tx      <= rd_word;
                                sda_low <= !rd_word[15];
                                bit_cnt <= 4'h1;
                            end else begin
                                state   <= ST_RECV;
                                sda_low <= 1'b0;
                            end
                        end
                    end
                    ST_SEND: begin
                        if (scl_fall) begin
                            if (bit_cnt == 4'h8) begin
                                state   <= ST_RACK;
                                sda_low <= 1'b0;
                            end else begin
                                sda_low <= !tx[14];
                                tx      <= {tx[14:0], 1'b0};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            rack_ok <= !sda_s;
                        end else if (scl_fall) begin
                            if (rack_ok && !second) begin
                                state   <= ST_SEND;
                                second  <= 1'b1;
                                sda_low <= !tx[14];
                                tx      <= {tx[14:0], 1'b0};
                                bit_cnt <= 4'h1;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // open drain: the pin is only ever pulled low
    assign LINK.dev_sda_out = 1'b0;
    assign LINK.dev_sda_oe  = sda_low;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            SERIAL_MODE <= 1'b0;
        end else if (hit) begin
            SERIAL_MODE <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            speed_demand <= `FSP_DUTY_OFF;
        end else if (wr_to(`FSP_REG_DEMAND)) begin
            speed_demand <= wr_data[8:0];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            run <= 1'b0;
        end else if (wr_to(`FSP_REG_DEMAND) && PARAMS_LOADED) begin
            run <= 1'b1;
        end
    end

    // parameter words have no reset; only the load mask is control state
    always_ff @(posedge REF_CLK) begin
        if (wr_stb && reg_index[7:5] == `FSP_PARAM_BASE) begin
            param_mem[reg_index[4:0]] <= wr_data;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            loaded_mask <= 23'h000000;
        end else if (wr_stb && reg_index >= `FSP_PARAM_FIRST && reg_index <= `FSP_PARAM_LAST) begin
            loaded_mask[5'(reg_index - `FSP_PARAM_FIRST)] <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            PARAMS_LOADED <= 1'b0;
        end else begin
            PARAMS_LOADED <= &loaded_mask;
        end
    end

    // a speed pin never seen low is the default pull-up level
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            low_seen <= 1'b0;
        end else if (!scl_s) begin
            low_seen <= 1'b1;
        end
    end

    // the event adds on top of a host write so no count is lost
    generate
        for (genvar i = 0; i < 2; i++) begin : g_count
            logic  ev;
            logic  wr;
            assign ev = (i == 0) ? STARTUP_FAIL : STARTUP_TRY;
            assign wr = wr_to((i == 0) ? `FSP_REG_FAILS : `FSP_REG_TRIES);
            always_ff @(posedge REF_CLK) begin
                if (!RST_N) begin
                    count[i] <= 16'h0000;
                end else if (wr) begin
                    count[i] <= wr_data + {15'h0000, ev};
                end else if (ev) begin
                    count[i] <= count[i] + 16'h0001;
                end
            end
        end
    endgenerate

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            lock_flags <= 7'h00;
        end else if (wr_to(`FSP_REG_LOCK) && wr_data[`FSP_LOCK_CLEAR_BIT]) begin
            lock_flags <= LOCK_EVENT;
        end else begin
            lock_flags <= lock_flags | LOCK_EVENT;
        end
    end

    always_comb begin
        if (SERIAL_MODE) begin
            next_duty = run ? speed_demand : `FSP_DUTY_OFF;
        end else if (!low_seen) begin
            next_duty = `FSP_DUTY_FULL;
        end else begin
            next_duty = PWM_DUTY;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            DUTY_CMD  <= `FSP_DUTY_OFF;
            MOTOR_RUN <= 1'b0;
        end else begin
            DUTY_CMD  <= next_duty;
            MOTOR_RUN <= (next_duty != `FSP_DUTY_OFF);
        end
    end
endmodule

// *** verilog/fan_port_host.sv ***
`include "fan_port_consts.svh"
module fan_port_host (
    // clock and reset
    input  wire logic                 REF_CLK,
    input  wire logic                 RST_N,
    // serial link
    fan_link_if.host                  LINK,
    // command port
    input  wire logic [1:0]           CMD_ADDR,
    input  wire fan_port_pkg::word_t  CMD_WDATA,
    input  wire logic                 CMD_WR,
    input  wire logic                 CMD_RD,
    output fan_port_pkg::word_t       CMD_RDATA
);
    import fan_port_pkg::*;

    localparam logic [3:0] QCYC = 4'(`FSP_QUARTER_CYC);

    host_state_t state;
    logic [3:0]  div;
    logic        tick;
    logic [1:0]  q;
    logic [3:0]  step;
    logic [3:0]  bit_no;
    logic        rd_mode;
    index_t      index;
    word_t       wdata;
    word_t       rx_word;
    logic        nack;
    logic        scl_low;
    logic        sda_low;
    logic        sda_s;
    logic        go;
    host_op_t    op;
    logic [7:0]  op_byte;
    logic [3:0]  last;

    // one transfer as a list of steps
    function automatic logic [9:0] host_op(input logic [3:0] s, input logic r);
        host_op_t k;
        logic [7:0] b;
        k = OP_STOP;
        b = 8'h00;
        case (s)
            4'h0: k = OP_START;
            4'h1: begin k = OP_TX; b = {`FSP_TARGET_ADDR, 1'b0}; end
            4'h2: begin k = OP_TX; b = index; end
            4'h3: begin k = r ? OP_STOP : OP_TX; b = wdata[15:8]; end
            4'h4: begin k = r ? OP_START : OP_TX; b = wdata[7:0]; end
            4'h5: k = r ? OP_TX : OP_STOP;
            4'h6: k = OP_RX;
            4'h7: k = OP_RX;
            default: k = OP_STOP;
        endcase
        if (s == 4'h5) begin
            b = {`FSP_TARGET_ADDR, 1'b1};
        end
        return {k, b};
    endfunction

    line_sync u_sda_sync (.clk(REF_CLK), .rst_n(RST_N), .d(LINK.sda), .q(sda_s));

    assign {op, op_byte} = host_op(step, rd_mode);
    assign last = rd_mode ? `FSP_H_LAST_READ : `FSP_H_LAST_WRITE;
    assign go   = CMD_WR && CMD_ADDR == `FSP_H_CTRL && state == H_IDLE;
    assign tick = (div == QCYC - 4'h1);

    always_ff @(posedge REF_CLK) begin
        if (!RST_N || state == H_IDLE || tick) begin
            div <= 4'h0;
        end else begin
            div <= div + 4'h1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            wdata <= 16'h0000;
        end else if (CMD_WR && CMD_ADDR == `FSP_H_WDATA) begin
            wdata <= CMD_WDATA;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            CMD_RDATA <= 16'h0000;
        end else if (CMD_RD) begin
            case (CMD_ADDR)
                `FSP_H_STATUS: CMD_RDATA <= {14'h0000, nack, state == H_RUN};
                `FSP_H_RDATA:  CMD_RDATA <= rx_word;
                `FSP_H_CTRL:   CMD_RDATA <= {7'h00, rd_mode, index};
                default:       CMD_RDATA <= wdata;
            endcase
        end else begin
            CMD_RDATA <= 16'h0000;
        end
    end

    // start is driven without waiting for a free line: a running fan may hold data low
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state   <= H_IDLE;
            q       <= 2'h0;
            step    <= 4'h0;
            bit_no  <= 4'h0;
            rd_mode <= 1'b0;
            index   <= 8'h00;
            rx_word <= 16'h0000;
            nack    <= 1'b0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
        end else if (state == H_IDLE) begin
            if (go) begin
                state   <= H_RUN;
                index   <= CMD_WDATA[7:0];
                rd_mode <= CMD_WDATA[`FSP_H_CTRL_READ];
                q       <= 2'h0;
                step    <= 4'h0;
                bit_no  <= 4'h0;
                nack    <= 1'b0;
            end
        end else if (tick) begin
            q <= q + 2'h1;
            unique case (op)
                OP_START: begin
                    if (q == 2'h0) begin
                        scl_low <= 1'b0;
                        sda_low <= 1'b0;
                    end else if (q == 2'h1) begin
                        sda_low <= 1'b1;
                    end else if (q == 2'h3) begin
                        scl_low <= 1'b1;
                        step    <= step + 4'h1;
                    end
                end
                OP_TX, OP_RX: begin
                    if (q == 2'h0) begin
                        if (bit_no == 4'h8) begin
                            sda_low <= (op == OP_RX) && (step == 4'h6);
                        end else begin
                            sda_low <= (op == OP_TX) && !op_byte[3'(4'h7 - bit_no)];
                        end
                    end else if (q == 2'h2) begin
                        scl_low <= 1'b0;
                    end else if (q == 2'h3) begin
                        scl_low <= 1'b1;
                        bit_no  <= bit_no + 4'h1;
                        if (op == OP_RX && bit_no != 4'h8) begin
                            rx_word <= {rx_word[14:0], sda_s};
                        end
                        if (bit_no == 4'h8) begin
                            bit_no <= 4'h0;
                            step   <= step + 4'h1;
                            if (op == OP_TX && sda_s) begin
                                nack <= 1'b1;
                                step <= last;
                            end
                        end
                    end
                end
                OP_STOP: begin
                    if (q == 2'h0) begin
                        sda_low <= 1'b1;
                    end else if (q == 2'h2) begin
                        scl_low <= 1'b0;
                    end else if (q == 2'h3) begin
                        sda_low <= 1'b0;
                        step    <= step + 4'h1;
                        if (step == last) begin
                            state <= H_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign LINK.host_scl_out = 1'b0;
    assign LINK.host_scl_oe  = scl_low;
    assign LINK.host_sda_out = 1'b0;
    assign LINK.host_sda_oe  = sda_low;
endmodule

// *** dv/fan_link_properties.sv ***
module fan_link_properties (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // link wires
    input wire logic host_scl_oe,
    input wire logic host_sda_out,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // open-drain: a driven high would fight the pull-up
    AST_HOST_OD: assert property (!host_sda_out) else $error("host drives data high");
    AST_DEV_OD: assert property (!dev_sda_out) else $error("device drives data high");
    AST_DEV_HOLD: assert property (scl && $past(scl) |-> $stable(dev_sda_oe)) else $error("device data moved");
    AST_DEV_RELEASE: assert property ($rose(dev_sda_oe) |-> ##[1:320] !dev_sda_oe) else $error("data held");
    // the host holds the clock high for at least one quarter, seven cycles
    AST_SCL_HIGH: assert property ($rose(scl) |-> scl[*7]) else $error("clock high too short");
    AST_SCL_LOW: assert property ($fell(scl) |-> !scl[*7] ##1 !scl[*6]) else $error("clock low too short");
    AST_SCL_BOUND: assert property ($fell(scl) |-> ##[1:40] scl) else $error("clock stuck low");
    AST_START_HOST: assert property ($fell(sda) && scl |-> !dev_sda_oe) else $error("device made a start");
    cover property ($rose(dev_sda_oe));
    cover property ($fell(sda) && scl);
    cover property ($rose(sda) && scl);
endmodule

// *** dv/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fan_port_pkg::*;
    logic       ref_clk = 0;
    logic       rst_n = 0;
    logic [1:0] cmd_addr = 0;
    word_t      cmd_wdata = 0;
    word_t      cmd_rdata;
    logic       cmd_wr = 0, cmd_rd = 0, try_p = 0, fail_p = 0, motor_run, serial_mode, params_loaded;
    duty_t      pwm_duty = 9'h0c8, duty_applied = 0, duty_cmd;
    logic [7:0] die_temp = 0;
    logic [9:0] fault = 0;
    logic [6:0] lock_event = 0;
    int         n_mismatch = 0, n_compared = 0;
    fan_link_if link ();
    always #50 ref_clk = ~ref_clk;
    fan_port_host fan_port_host_i (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(link), .CMD_ADDR(cmd_addr),
        .CMD_WDATA(cmd_wdata), .CMD_WR(cmd_wr), .CMD_RD(cmd_rd), .CMD_RDATA(cmd_rdata));
    fan_port_device fan_port_device_i (.REF_CLK(ref_clk), .RST_N(rst_n), .LINK(link), .PWM_DUTY(pwm_duty),
        .DUTY_APPLIED(duty_applied), .DIE_TEMP(die_temp), .FAULT(fault), .LOCK_EVENT(lock_event),
        .STARTUP_TRY(try_p), .STARTUP_FAIL(fail_p), .DUTY_CMD(duty_cmd), .MOTOR_RUN(motor_run),
        .SERIAL_MODE(serial_mode), .PARAMS_LOADED(params_loaded));
    fan_link_properties fan_link_properties_i (.REF_CLK(ref_clk), .RST_N(rst_n),
        .host_scl_oe(link.host_scl_oe), .host_sda_out(link.host_sda_out), .dev_sda_out(link.dev_sda_out),
        .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
    task automatic chk(input word_t got, input word_t exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one command-port cycle; read data is taken mid-cycle where it stands
    task automatic strobe(input logic [1:0] a, input word_t d, input logic rd);
        @(posedge ref_clk);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= !rd;
        cmd_rd <= rd;
        @(posedge ref_clk);
        cmd_wr <= 0;
        cmd_rd <= 0;
        @(negedge ref_clk);
    endtask
    task automatic wait_idle();
        word_t s;
        s = 16'h0001;
        for (int i = 0; i < 3000 && s[0] !== 1'b0; i++) begin
            strobe(2'h2, 16'h0000, 1'b1);
            s = cmd_rdata;
        end
        chk(s, 16'h0000);
    endtask
    task automatic reg_wr(input index_t idx, input word_t d);
        strobe(2'h1, d, 1'b0);
        strobe(2'h0, {8'h00, idx}, 1'b0);
        wait_idle();
    endtask
    task automatic reg_rd(input index_t idx, input word_t exp);
        strobe(2'h0, {8'h01, idx}, 1'b0);
        wait_idle();
        strobe(2'h3, 16'h0000, 1'b1);
        chk(cmd_rdata, exp);
    endtask
    task automatic t_power_up();
        @(negedge ref_clk);
        chk({7'h00, duty_cmd}, 16'h01ff);
        chk({14'h0000, motor_run, serial_mode}, 16'h0002);
    endtask
    task automatic t_readback();
        @(posedge ref_clk);
        duty_applied <= 9'h123;
        die_temp <= 8'h85;
        fault <= 10'h2a5;
        reg_rd(8'h80, 16'h0123);
        chk({14'h0000, motor_run, serial_mode}, 16'h0001);
        chk({7'h00, duty_cmd}, 16'h0000);
        reg_rd(8'h8a, 16'h0085);
        reg_rd(8'h93, 16'h02a5);
    endtask
    task automatic t_demand();
        reg_wr(8'ha5, 16'h0066);
        chk({7'h00, duty_cmd}, 16'h0000);
        reg_rd(8'ha5, 16'h0066);
        for (int i = 8'h48; i < 8'h5e; i++)
            reg_wr(i[7:0], i[15:0]);
        chk({15'h0000, params_loaded}, 16'h0000);
        reg_wr(8'h5e, 16'h005e);
        chk({15'h0000, params_loaded}, 16'h0001);
        reg_rd(8'h50, 16'h0050);
        reg_wr(8'ha5, 16'h0066);
        chk({7'h00, duty_cmd}, 16'h0066);
    endtask
    // mid-run reset; pwm duty applies from the first clock low until the address match
    task automatic t_pwm_mode();
        @(posedge ref_clk);
        rst_n <= 0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1;
        repeat (3) @(posedge ref_clk);
        t_power_up();
        strobe(2'h0, 16'h0180, 1'b0);
        repeat (100) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({7'h00, duty_cmd}, 16'h00c8);
        wait_idle();
        strobe(2'h3, 16'h0000, 1'b1);
        chk(cmd_rdata, 16'h0123);
        chk({14'h0000, motor_run, serial_mode}, 16'h0001);
    endtask
    task automatic t_counters();
        reg_rd(8'h91, 16'h0000);
        @(posedge ref_clk);
        try_p <= 1;
        fail_p <= 1;
        lock_event <= 7'h45;
        repeat (2) @(posedge ref_clk);
        fail_p <= 0;
        lock_event <= 0;
        @(posedge ref_clk);
        try_p <= 0;
        reg_rd(8'h91, 16'h0003);
        reg_rd(8'h90, 16'h0002);
        reg_wr(8'h91, 16'h0000);
        reg_rd(8'h91, 16'h0000);
        reg_wr(8'h90, 16'h0000);
        reg_rd(8'h90, 16'h0000);
        reg_rd(8'h94, 16'h0045);
        reg_wr(8'h94, 16'h8000);
        reg_rd(8'h94, 16'h0000);
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1;
        repeat (3) @(posedge ref_clk);
        t_power_up();
        t_readback();
        t_demand();
        t_counters();
        t_pwm_mode();
        conclude();
    end
    // about 48k cycles of link traffic expected
    initial begin
        repeat (95000) @(posedge ref_clk);
        n_mismatch++;
        conclude();
    end
endmodule
